//--- dv/acf_ctrl_test.sv
// Self-checking bench for the converter channel scan and result registers
`timescale 1ns/1ps
module acf_ctrl_test;
   logic                        clk_i;
   logic                        rstn_i;
   logic [7:0]                  reg_addr_i;
   logic                        reg_wr_i;
   logic [7:0]                  reg_wdata_i;
   logic                        reg_rd_i;
   logic [7:0]                  reg_rdata_o;
   acf_pkg::acf_req_type        conv_req_o;
   logic                        conv_start_o;
   logic                        conv_done_i;
   logic signed [15:0]          conv_raw_i;
   logic                        busy_o;
   logic                        data_ready_o;
   int                          num_errors;
   int                          num_checks;

   acf_ctrl i_dut (
      .clk_i        (clk_i),
      .rstn_i       (rstn_i),
      .reg_addr_i   (reg_addr_i),
      .reg_wr_i     (reg_wr_i),
      .reg_wdata_i  (reg_wdata_i),
      .reg_rd_i     (reg_rd_i),
      .reg_rdata_o  (reg_rdata_o),
      .conv_req_o   (conv_req_o),
      .conv_start_o (conv_start_o),
      .conv_done_i  (conv_done_i),
      .conv_raw_i   (conv_raw_i),
      .busy_o       (busy_o),
      .data_ready_o (data_ready_o)
   );

   // Free-running 10 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t ns: got 0x%h, expected 0x%h", $time, got, exp);
         num_errors++;
      end
   endtask

   // Strobes change at the falling edge so the rising edge sees settled values
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_i);
      reg_addr_i  = addr;
      reg_wdata_i = data;
      reg_wr_i    = 1'b1;
      @(negedge clk_i);
      reg_wr_i    = 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk_i);
      reg_addr_i = addr;
      reg_rd_i   = 1'b1;
      @(negedge clk_i);
      reg_rd_i   = 1'b0;
      @(negedge clk_i);
      data       = reg_rdata_o;
   endtask

   // Reads a result pair, high byte at the lower address
   task automatic check_word(input logic [7:0] hi_addr, input logic [15:0] exp);
      logic [7:0] hi;
      logic [7:0] lo;
      reg_read(hi_addr, hi);
      reg_read(hi_addr + 8'h01, lo);
      check({hi, lo}, exp);
   endtask

   // Acts as the analog converter for one channel
   task automatic serve(input logic [3:0] mux, input logic refv, input logic [15:0] raw,
                        input bit go_also = 1'b0);
      int n;
      n = 0;
      @(negedge clk_i);
      while (conv_start_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      check({15'h0000, conv_start_o}, 16'h0001);
      check({12'h000, conv_req_o.mux}, {12'h000, mux});
      check({15'h0000, conv_req_o.refsel}, {15'h0000, refv});
      @(negedge clk_i);
      conv_raw_i  = raw;
      conv_done_i = 1'b1;
      if (go_also) begin
         // Go issued mid-pass must be ignored; done here so no start pulse is missed
         reg_addr_i  = acf_pkg::ADDR_CONVERT;
         reg_wdata_i = 8'h01;
         reg_wr_i    = 1'b1;
      end
      @(negedge clk_i);
      conv_done_i = 1'b0;
      reg_wr_i    = 1'b0;
      conv_raw_i  = ~raw;   // Stale value must not be picked up again
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (data_ready_o !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      check({14'h0000, data_ready_o, busy_o}, 16'h0002);
   endtask

   task automatic test_reset_values();
      logic [7:0] d;
      reg_read(acf_pkg::ADDR_SETUP, d);
      check({8'h00, d}, 16'h0000);
      reg_read(acf_pkg::ADDR_FUNC, d);
      check({8'h00, d}, 16'h0000);
      reg_read(8'hFF, d);
      check({8'h00, d}, 16'h0000);
      check_word(acf_pkg::ADDR_CELL1_HI, 16'h0000);
   endtask

   // Two cells, second temperature and aux pin; clamps at both ends
   task automatic test_mixed_scan();
      logic [7:0] d;
      reg_write(acf_pkg::ADDR_SETUP, 8'h61);
      reg_write(acf_pkg::ADDR_FUNC, 8'h40);
      reg_write(acf_pkg::ADDR_CONVERT, 8'h01);
      serve(acf_pkg::MUX_AUX_PIN, acf_pkg::REF_BANDGAP, 16'h2000);
      serve(acf_pkg::MUX_CELL1, acf_pkg::REF_BANDGAP, 16'h224D);
      serve(acf_pkg::MUX_CELL2, acf_pkg::REF_BANDGAP, 16'hFFFB);
      serve(acf_pkg::MUX_TS2, acf_pkg::REF_REGULATOR, 16'h4E20);
      wait_ready();
      check_word(8'h01, 16'h2000);
      check_word(acf_pkg::ADDR_CELL1_HI, 16'h224D);
      check_word(8'h05, 16'h0000);
      check_word(8'h11, 16'h3FFF);
      check_word(8'h0F, 16'h0000);
      check_word(8'h07, 16'h0000);
      reg_read(acf_pkg::ADDR_STATUS, d);
      check({8'h00, d}, 16'h0002);
      // Results are read-only
      reg_write(acf_pkg::ADDR_CELL1_HI, 8'hAA);
      check_word(acf_pkg::ADDR_CELL1_HI, 16'h224D);
   endtask

   // Aux source and reference choices, with brick forcing the bandgap
   task automatic test_aux_sources();
      reg_write(acf_pkg::ADDR_SETUP, 8'h40);
      reg_write(acf_pkg::ADDR_FUNC, 8'h10);
      reg_write(acf_pkg::ADDR_CONVERT, 8'h01);
      serve(acf_pkg::MUX_BRICK, acf_pkg::REF_BANDGAP, 16'h26F7);
      serve(acf_pkg::MUX_CELL1, acf_pkg::REF_BANDGAP, 16'h3FFF);
      wait_ready();
      check_word(8'h01, 16'h26F7);
      reg_write(acf_pkg::ADDR_FUNC, 8'h00);
      reg_write(acf_pkg::ADDR_CONVERT, 8'h01);
      serve(acf_pkg::MUX_AUX_PIN, acf_pkg::REF_REGULATOR, 16'h1116);
      serve(acf_pkg::MUX_CELL1, acf_pkg::REF_BANDGAP, 16'h0001);
      wait_ready();
      check_word(8'h01, 16'h1116);
      check_word(acf_pkg::ADDR_CELL1_HI, 16'h0001);
   endtask

   // Count field above five still scans six cells; go while busy is ignored
   task automatic test_full_scan();
      int any;
      reg_write(acf_pkg::ADDR_SETUP, 8'h17);
      reg_write(acf_pkg::ADDR_CONVERT, 8'h01);
      for (int i = 0; i < 6; i++) begin
         serve(4'(i), acf_pkg::REF_BANDGAP, 16'h0100 + 16'(i), i == 0);
      end
      serve(acf_pkg::MUX_TS1, acf_pkg::REF_REGULATOR, 16'h0ABC);
      wait_ready();
      for (int i = 0; i < 6; i++) begin
         check_word(8'h03 + 8'(2 * i), 16'h0100 + 16'(i));
      end
      check_word(8'h0F, 16'h0ABC);
      // No second pass may follow the ignored go
      any = 0;
      repeat (20) begin
         @(negedge clk_i);
         if (conv_start_o !== 1'b0) begin
            any = 1;
         end
      end
      check(16'(any), 16'h0000);
   endtask

   // Watchdog sized well above the few hundred cycles the scenarios need
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      complete_run();
   end

   initial begin
      num_errors  = 0;
      num_checks  = 0;
      rstn_i      = 1'b0;
      reg_addr_i  = 8'h00;
      reg_wr_i    = 1'b0;
      reg_wdata_i = 8'h00;
      reg_rd_i    = 1'b0;
      conv_done_i = 1'b0;
      conv_raw_i  = 16'hA5A5;
      repeat (16) @(negedge clk_i);
      rstn_i = 1'b1;
      test_reset_values();
      test_mixed_scan();
      test_aux_sources();
      test_full_scan();
      complete_run();
   end
endmodule // acf_ctrl_test

//--- shared/acf_pkg.sv
// Constants, register map and carrier types of the converter channel and result block
// How it works
// - Each result is 14 unsigned bits in a 16-bit word, top two bits zero.
// - A result word sits in two byte registers, high byte at the lower address.
// - Cell one result lives at 0x03 (high byte) and 0x04 (low byte).
// - Results clamp at zero and at full scale instead of wrapping.
// - The front end selects among six cells, two temperature inputs, the aux pin and the brick input.
// - The cell count field limits the scan to connected cells only.
// - Cell code 16383 means 6250 mV, linear in between.
// - Aux source bit chooses aux pin voltage or brick voltage for the aux result.
// - Brick voltage is its own multiplexer input, apart from the cell taps.
// - Aux reference bit chooses bandgap or five volt regulator for the aux input.
// - With the regulator reference the aux result is a ratio to the regulator.
// - Brick measurement forces the bandgap and ignores the aux reference bit.
// - Cell and brick conversions always use the bandgap.
// - Aux code 16383 means 2500 mV with the bandgap reference.
// - A temperature channel converts only when its own setup select bit is set.
package acf_pkg;

   // Converter data widths
   localparam int RESULT_BITS = 14;
   localparam int WORD_BITS   = 16;
   localparam int RAW_BITS    = 16;
   localparam int BYTE_BITS   = 8;
   localparam int MAX_CELLS   = 6;
   localparam int NUM_SLOTS   = 9;
   localparam int SLOT_W      = 4;

   // Register byte addresses
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_RES_BASE = 8'h01;   // Slot 0 high byte, aux result
   localparam logic [7:0] ADDR_CELL1_HI = 8'h03;
   localparam logic [7:0] ADDR_CELL1_LO = 8'h04;
   localparam logic [7:0] ADDR_RES_LAST = 8'h12;   // Slot 8 low byte
   localparam logic [7:0] ADDR_SETUP    = 8'h30;
   localparam logic [7:0] ADDR_CONVERT  = 8'h34;
   localparam logic [7:0] ADDR_FUNC     = 8'h40;

   // Result slots: aux, cells one to six, temperature one and two
   localparam logic [SLOT_W-1:0] SLOT_AUX   = 4'h0;
   localparam logic [SLOT_W-1:0] SLOT_CELL1 = 4'h1;
   localparam logic [SLOT_W-1:0] SLOT_TS1   = 4'h7;
   localparam logic [SLOT_W-1:0] SLOT_TS2   = 4'h8;

   // Setup register fields
   localparam int SETUP_COUNT_LSB = 0;
   localparam int SETUP_COUNT_W   = 3;
   localparam int SETUP_TS1_BIT   = 4;
   localparam int SETUP_TS2_BIT   = 5;
   localparam int SETUP_AUX_BIT   = 6;
   localparam logic [7:0] SETUP_RESET = 8'h00;

   // Function configuration fields
   localparam int FUNC_SRC_BIT = 4;                // 1 selects brick voltage
   localparam int FUNC_REF_BIT = 6;                // 1 selects bandgap
   localparam logic [7:0] FUNC_RESET = 8'h00;

   // Convert and status fields
   localparam int CONV_GO_BIT    = 0;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_READY_BIT = 1;

   // Scale of results in millivolts at code 16383
   localparam int FULL_SCALE_CODE = 16383;
   localparam int CELL_FULL_MV    = 6250;
   localparam int AUX_FULL_MV     = 2500;

   // Multiplexer inputs; brick is separate from the taps
   typedef enum logic [3:0] {
      MUX_CELL1, MUX_CELL2, MUX_CELL3, MUX_CELL4, MUX_CELL5, MUX_CELL6,
      MUX_TS1, MUX_TS2, MUX_AUX_PIN, MUX_BRICK
   } acf_mux_type;

   typedef enum logic {
      REF_BANDGAP, REF_REGULATOR
   } acf_ref_type;

   // Request handed to the analog converter
   typedef struct packed {
      acf_mux_type mux;
      acf_ref_type refsel;
   } acf_req_type;

endpackage : acf_pkg

//--- src/acf_ctrl.sv
// Channel scan, reference choice and result registers of the measurement converter
`timescale 1ns/1ps
module acf_ctrl #(
   parameter int CELLS  = acf_pkg::MAX_CELLS,
   parameter int DATA_W = acf_pkg::RESULT_BITS,
   parameter int RAW_W  = acf_pkg::RAW_BITS
) (
   input  wire logic                     clk_i,
   input  wire logic                     rstn_i,
   // Register port
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic                     reg_wr_i,
   input  wire logic [7:0]               reg_wdata_i,
   input  wire logic                     reg_rd_i,
   output logic      [7:0]               reg_rdata_o,
   // Analog converter handshake
   output acf_pkg::acf_req_type          conv_req_o,
   output logic                          conv_start_o,
   input  wire logic                     conv_done_i,
   input  wire logic signed [RAW_W-1:0]  conv_raw_i,
   // Status
   output logic                          busy_o,
   output logic                          data_ready_o
);

   localparam int N = acf_pkg::NUM_SLOTS;
   localparam int W = acf_pkg::WORD_BITS;

   if (CELLS != acf_pkg::MAX_CELLS || DATA_W > W - 2) begin : g_bad
      $error("acf_ctrl: unsupported cell count or data width");
   end

   typedef enum {ST_IDLE, ST_LAUNCH, ST_WAIT} acf_state_type;

   acf_state_type                 state_r;
   logic [7:0]                    setup_r;
   logic [7:0]                    func_r;
   logic [N-1:0]                  pend_r;
   logic [N-1:0]                  pend_nxt;
   logic [acf_pkg::SLOT_W-1:0]    slot_r;
   logic                          src_brick_r;
   logic                          ref_gap_r;
   logic [W-1:0]                  res_r [N];
   logic [W-1:0]                  sat_word;
   logic [acf_pkg::SLOT_W-1:0]    pick_idx;
   logic                          pick_any;
   logic                          go_wr;
   acf_pkg::acf_req_type          req_nxt;
   logic [2:0]                    count_f;
   logic [7:0]                    setup_lat_r;
   logic [2:0]                    count_lat;
   logic [acf_pkg::SLOT_W-1:0]    rd_slot;

   assign count_f = setup_r[acf_pkg::SETUP_COUNT_LSB +: acf_pkg::SETUP_COUNT_W];
   assign go_wr   = reg_wr_i && (reg_addr_i == acf_pkg::ADDR_CONVERT)
                    && reg_wdata_i[acf_pkg::CONV_GO_BIT];
   assign count_lat = setup_lat_r[acf_pkg::SETUP_COUNT_LSB +: acf_pkg::SETUP_COUNT_W];
   // Result slot of a read; the high byte sits at the odd address of each pair
   assign rd_slot   = acf_pkg::SLOT_W'((reg_addr_i - acf_pkg::ADDR_RES_BASE) >> 1);

   // Scan mask built at start; unused taps are skipped so the pass ends sooner
   always_comb begin
      pend_nxt = '0;
      pend_nxt[acf_pkg::SLOT_AUX] = setup_r[acf_pkg::SETUP_AUX_BIT];
      for (int c = 0; c < CELLS; c++) begin
         pend_nxt[int'(acf_pkg::SLOT_CELL1) + c] = (3'(c) <= count_f);
      end
      pend_nxt[acf_pkg::SLOT_TS1] = setup_r[acf_pkg::SETUP_TS1_BIT];
      pend_nxt[acf_pkg::SLOT_TS2] = setup_r[acf_pkg::SETUP_TS2_BIT];
   end

   acf_pick #(
      .N     (N),
      .IDX_W (acf_pkg::SLOT_W)
   ) u_pick (
      .mask_i (pend_r),
      .idx_o  (pick_idx),
      .any_o  (pick_any)
   );

   acf_sat #(
      .RAW_W  (RAW_W),
      .DATA_W (DATA_W)
   ) u_sat (
      .raw_i  (conv_raw_i),
      .word_o (sat_word)
   );

   // Mux input and reference for the picked slot
   always_comb begin
      req_nxt.mux    = acf_pkg::MUX_CELL1;
      req_nxt.refsel = acf_pkg::REF_BANDGAP;
      unique case (pick_idx)
         acf_pkg::SLOT_AUX: begin
            if (src_brick_r) begin
               req_nxt.mux    = acf_pkg::MUX_BRICK;
               req_nxt.refsel = acf_pkg::REF_BANDGAP;
            end else begin
               req_nxt.mux    = acf_pkg::MUX_AUX_PIN;
               req_nxt.refsel = ref_gap_r ? acf_pkg::REF_BANDGAP
                                          : acf_pkg::REF_REGULATOR;
            end
         end
         acf_pkg::SLOT_TS1: begin
            req_nxt.mux    = acf_pkg::MUX_TS1;
            req_nxt.refsel = acf_pkg::REF_REGULATOR;
         end
         acf_pkg::SLOT_TS2: begin
            req_nxt.mux    = acf_pkg::MUX_TS2;
            req_nxt.refsel = acf_pkg::REF_REGULATOR;
         end
         default: begin
            // Cell taps; slots above the map cannot be picked
            req_nxt.mux = acf_pkg::acf_mux_type'(4'(pick_idx - acf_pkg::SLOT_CELL1));
         end
      endcase
   end

   // Configuration registers written by software
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         setup_r <= acf_pkg::SETUP_RESET;
         func_r  <= acf_pkg::FUNC_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == acf_pkg::ADDR_SETUP) begin
            setup_r <= reg_wdata_i;
         end
         if (reg_addr_i == acf_pkg::ADDR_FUNC) begin
            func_r <= reg_wdata_i;
         end
      end
   end

   // Scan sequencer; settings are latched at start so a mid-pass write cannot mix modes
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r      <= ST_IDLE;
         pend_r       <= '0;
         slot_r       <= '0;
         src_brick_r  <= 1'b0;
         ref_gap_r    <= 1'b0;
         setup_lat_r  <= acf_pkg::SETUP_RESET;
         conv_start_o <= 1'b0;
         conv_req_o   <= '0;
         busy_o       <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               if (go_wr) begin
                  pend_r      <= pend_nxt;
                  setup_lat_r <= setup_r;
                  src_brick_r <= func_r[acf_pkg::FUNC_SRC_BIT];
                  ref_gap_r   <= func_r[acf_pkg::FUNC_REF_BIT];
                  busy_o      <= 1'b1;
                  state_r     <= ST_LAUNCH;
               end
            end
            ST_LAUNCH: begin
               if (pick_any) begin
                  slot_r       <= pick_idx;
                  conv_req_o   <= req_nxt;
                  conv_start_o <= 1'b1;
                  state_r      <= ST_WAIT;
               end else begin
                  busy_o  <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (conv_done_i) begin
                  pend_r[slot_r] <= 1'b0;
                  state_r        <= ST_LAUNCH;
               end
            end
         endcase
      end
   end

   // Data ready: set the cycle after the last word is stored, cleared by the next start
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_ready_o <= 1'b0;
      end else if (state_r == ST_LAUNCH && !pick_any) begin
         data_ready_o <= 1'b1;
      end else if (state_r == ST_IDLE && go_wr) begin
         data_ready_o <= 1'b0;
      end
   end

   // Whole word written at once at conversion end; byte reads are not latched, so a pair read may span two conversions
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int s = 0; s < N; s++) begin
            res_r[s] <= '0;
         end
      end else if (state_r == ST_WAIT && conv_done_i) begin
         res_r[slot_r] <= sat_word;
      end
   end

   // Read port: one cycle latency, unmapped reads return zero
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         if (reg_addr_i >= acf_pkg::ADDR_RES_BASE && reg_addr_i <= acf_pkg::ADDR_RES_LAST) begin
            // High byte at the lower address of each pair
            if (reg_addr_i[0]) begin
               reg_rdata_o <= res_r[rd_slot][15:8];
            end else begin
               reg_rdata_o <= res_r[rd_slot][7:0];
            end
         end else if (reg_addr_i == acf_pkg::ADDR_STATUS) begin
            reg_rdata_o <= {6'h00, data_ready_o, busy_o};
         end else if (reg_addr_i == acf_pkg::ADDR_SETUP) begin
            reg_rdata_o <= setup_r;
         end else if (reg_addr_i == acf_pkg::ADDR_FUNC) begin
            reg_rdata_o <= func_r;
         end else if (reg_addr_i == acf_pkg::ADDR_CONVERT) begin
            reg_rdata_o <= {7'h00, busy_o};       // Go bit self-clears at end of pass
         end else begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

   // Checks on the design's own outputs and result registers
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   AST_HIGH_BYTE_TOP_ZERO: assert property (
      reg_rd_i && reg_addr_i >= acf_pkg::ADDR_RES_BASE
      && reg_addr_i <= acf_pkg::ADDR_RES_LAST && reg_addr_i[0]
      |=> reg_rdata_o[7:6] == 2'b00)
      else $error("Result high byte has top bits set");

   AST_CELL1_PAIR: assert property (
      reg_rd_i
      && (reg_addr_i == acf_pkg::ADDR_CELL1_HI || reg_addr_i == acf_pkg::ADDR_CELL1_LO)
      |=> reg_rdata_o == (($past(reg_addr_i) == acf_pkg::ADDR_CELL1_HI)
                          ? $past(res_r[acf_pkg::SLOT_CELL1][15:8])
                          : $past(res_r[acf_pkg::SLOT_CELL1][7:0])))
      else $error("Cell one pair not big endian at 0x03 and 0x04");

   AST_SAT_LOW: assert property (
      state_r == ST_WAIT && conv_done_i && conv_raw_i < 0
      |=> res_r[$past(slot_r)] == '0)
      else $error("Negative reading did not clamp to zero");

   AST_SAT_HIGH: assert property (
      state_r == ST_WAIT && conv_done_i && conv_raw_i >= RAW_W'(1 << DATA_W)
      |=> res_r[$past(slot_r)] == W'((1 << DATA_W) - 1))
      else $error("Over-range reading did not clamp to full scale");

   AST_CELL_LIMIT: assert property (
      conv_start_o && conv_req_o.mux <= acf_pkg::MUX_CELL6
      |-> 3'(conv_req_o.mux) <= count_lat)
      else $error("Cell beyond count was scanned");

   AST_BRICK_BANDGAP: assert property (
      conv_start_o && conv_req_o.mux == acf_pkg::MUX_BRICK
      |-> conv_req_o.refsel == acf_pkg::REF_BANDGAP && src_brick_r)
      else $error("Brick conversion not on bandgap");

   AST_CELL_BANDGAP: assert property (
      conv_start_o && conv_req_o.mux <= acf_pkg::MUX_CELL6
      |-> conv_req_o.refsel == acf_pkg::REF_BANDGAP)
      else $error("Cell conversion not on bandgap");

   AST_AUX_RATIO: assert property (
      conv_start_o && conv_req_o.mux == acf_pkg::MUX_AUX_PIN && !ref_gap_r
      |-> conv_req_o.refsel == acf_pkg::REF_REGULATOR)
      else $error("Aux pin with regulator choice not ratiometric");

   AST_AUX_BANDGAP: assert property (
      conv_start_o && conv_req_o.mux == acf_pkg::MUX_AUX_PIN && ref_gap_r
      |-> conv_req_o.refsel == acf_pkg::REF_BANDGAP)
      else $error("Aux pin with bandgap choice not on bandgap");

   AST_SRC_PIN: assert property (
      conv_start_o && conv_req_o.mux == acf_pkg::MUX_AUX_PIN
      |-> !src_brick_r)
      else $error("Aux pin converted while brick was chosen");

   AST_RAW_PASS: assert property (
      state_r == ST_WAIT && conv_done_i && conv_raw_i >= 0
      && conv_raw_i < RAW_W'(1 << DATA_W)
      |=> res_r[$past(slot_r)] == W'($past(conv_raw_i)))
      else $error("In-range reading not stored unchanged");

   AST_TS_SELECT: assert property (
      conv_start_o && conv_req_o.mux == acf_pkg::MUX_TS1
      |-> setup_lat_r[acf_pkg::SETUP_TS1_BIT])
      else $error("Unselected temperature channel converted");

   AST_TS2_SELECT: assert property (
      conv_start_o && conv_req_o.mux == acf_pkg::MUX_TS2
      |-> setup_lat_r[acf_pkg::SETUP_TS2_BIT])
      else $error("Unselected second temperature channel converted");

   AST_PAIR_ONLY_AT_DONE: assert property (
      !(state_r == ST_WAIT && conv_done_i) |=> $stable(res_r[slot_r]) || $changed(slot_r))
      else $error("Result word changed outside conversion end");

endmodule // acf_ctrl

//--- src/acf_pick.sv
// Finds the lowest pending slot in a request mask
`timescale 1ns/1ps
module acf_pick #(
   parameter int N     = acf_pkg::NUM_SLOTS,
   parameter int IDX_W = acf_pkg::SLOT_W
) (
   input  wire logic [N-1:0]     mask_i,
   output logic      [IDX_W-1:0] idx_o,
   output logic                  any_o
);

   logic [N:0]       seen;
   logic [IDX_W-1:0] part [N+1];

   if (N > (1 << IDX_W)) begin : g_bad
      $error("acf_pick: index too narrow");
   end

   assign seen[0] = 1'b0;
   assign part[0] = '0;

   // Priority chain, lowest bit wins
   for (genvar i = 0; i < N; i++) begin : g_bit
      assign seen[i+1] = seen[i] | mask_i[i];
      assign part[i+1] = part[i] | ((mask_i[i] && !seen[i]) ? IDX_W'(i) : '0);
   end

   assign idx_o = part[N];
   assign any_o = seen[N];

endmodule // acf_pick

//--- src/acf_sat.sv
// Clamps a signed trimmed converter value to the unsigned result range
`timescale 1ns/1ps
module acf_sat #(
   parameter int RAW_W  = acf_pkg::RAW_BITS,
   parameter int DATA_W = acf_pkg::RESULT_BITS
) (
   input  wire logic signed [RAW_W-1:0]           raw_i,
   output logic             [acf_pkg::WORD_BITS-1:0] word_o
);

   localparam logic signed [RAW_W-1:0] TOP = RAW_W'((1 << DATA_W) - 1);

   // Refuse widths the clamp cannot serve
   if (RAW_W <= DATA_W || DATA_W >= acf_pkg::WORD_BITS) begin : g_bad
      $error("acf_sat: raw width must exceed data width");
   end

   // Offset may push either way; clamp rather than wrap
   always_comb begin
      if (raw_i < 0) begin
         word_o = '0;
      end else if (raw_i > TOP) begin
         word_o = acf_pkg::WORD_BITS'(TOP);
      end else begin
         word_o = acf_pkg::WORD_BITS'(raw_i[DATA_W-1:0]);
      end
   end

endmodule // acf_sat
